// file: src/thlc_defines.svh
// register indices, field positions, reset values and response codes of the timer control block
`ifndef THLC_DEFINES_SVH
`define THLC_DEFINES_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define THLC_IDX_W        14
`define THLC_IDX_COUNTER  14'h03a1
`define THLC_IDX_CTRL     14'h03a2
`define THLC_IDX_HLT      14'h03a3
`define THLC_IDX_PS       14'h03a4
`define THLC_IDX_PERIOD   14'h03a5
`define THLC_IDX_CNT_HI   14'h03a6
`define THLC_IDX_CNT_LO   14'h03a7

// ****************************************************************
// field positions
// ****************************************************************
`define THLC_CTRL_EN      0
`define THLC_CTRL_OS      1
`define THLC_CTRL_VSEL    2
`define THLC_CTRL_RUN     7
`define THLC_HLT_POL      7
`define THLC_HLT_SYNC     6
`define THLC_HLT_START_HI 5
`define THLC_HLT_START_LO 4
`define THLC_HLT_RST_HI   3
`define THLC_HLT_RST_LO   2
`define THLC_HLT_STOP_HI  1
`define THLC_HLT_STOP_LO  0

// ****************************************************************
// reset values and bus answers
// ****************************************************************
`define THLC_HLT_RST      8'h40
`define THLC_PS_RST       8'h00
`define THLC_PER_RST      16'hffff
`define THLC_CNT_RST      16'h0000
`define THLC_RESP_OKAY    2'h0
`define THLC_RESP_SLVERR  2'h2

`endif

// file: src/thlc_pkg.sv
// types of the timer control block: selector codes and run state
package thlc_pkg;

	typedef enum logic [1:0] {
		START_NONE  = 2'h0, START_BOTH = 2'h1, START_RISE = 2'h2, START_LEVEL = 2'h3
	} thlc_start_e;

	typedef enum logic [1:0] {
		RST_NONE = 2'h0, RST_LOW = 2'h1, RST_FIRST = 2'h2, RST_MATCH = 2'h3
	} thlc_reset_e;

	typedef enum logic [1:0] {
		STOP_NONE = 2'h0, STOP_BOTH = 2'h1, STOP_RISE = 2'h2, STOP_MATCH = 2'h3
	} thlc_stop_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h1, ST_RUN = 2'h2
	} thlc_state_e;

endpackage : thlc_pkg

// file: src/thlc_top.sv
// timer start/reset/stop control, prescaler, counter and capture behind an AXI4-Lite slave
`timescale 1ns/1ns
`include "thlc_defines.svh"
module thlc_top (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [15:0] awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [15:0] araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	input  wire logic        timer_clock_in,
	input  wire logic        external_reset_source,
	output logic             counter_run
);

	// ****************************************************************
	// state
	// ****************************************************************
	logic [1:0]              tclk_sync_q;
	logic                    tclk_last_q;
	logic [1:0]              src_sync_q;
	logic                    src_last_q;
	logic                    on_sync_q;
	logic                    en_q;
	logic                    os_q;
	logic                    vsel_q;
	logic [7:0]              hlt_q;
	logic [7:0]              ps_q;
	logic [7:0]              ps_cnt_q;
	logic [15:0]             per_buf_q;
	logic [15:0]             per_eff_q;
	logic [15:0]             cnt_q;
	logic [15:0]             cap_q;
	logic                    rst_pend_q;
	thlc_pkg::thlc_state_e   state_q;
	logic                    aw_full_q;
	logic                    w_full_q;
	logic [`THLC_IDX_W-1:0]  aw_idx_q;
	logic [31:0]             wdata_q;
	logic [3:0]              wstrb_q;
	logic                    bvalid_q;
	logic [1:0]              bresp_q;
	logic                    rvalid_q;
	logic [31:0]             rdata_q;
	logic [1:0]              rresp_q;

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	// two flops before any logic reads the pins
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			tclk_sync_q <= 2'h0;
			tclk_last_q <= 1'b0;
			src_sync_q  <= 2'h0;
		end else begin
			tclk_sync_q <= {tclk_sync_q[0], timer_clock_in};
			tclk_last_q <= tclk_sync_q[1];
			src_sync_q  <= {src_sync_q[0], external_reset_source};
		end
	end

	// ****************************************************************
	// field decode and event terms
	// ****************************************************************
	thlc_pkg::thlc_start_e start_sel;
	thlc_pkg::thlc_reset_e rst_sel;
	thlc_pkg::thlc_stop_e  stop_sel;
	logic tick, syn, on_eff, evt_cyc, src_pol, rise, fall, running, cnt_tick, match;
	logic start_hit, start_evt, stop_hit, cap_evt, first_set;
	logic match_rst, low_rst, first_rst, rst_evt, ps_clr, run_status;

	assign start_sel = thlc_pkg::thlc_start_e'(hlt_q[`THLC_HLT_START_HI:`THLC_HLT_START_LO]);
	assign rst_sel   = thlc_pkg::thlc_reset_e'(hlt_q[`THLC_HLT_RST_HI:`THLC_HLT_RST_LO]);
	assign stop_sel  = thlc_pkg::thlc_stop_e'(hlt_q[`THLC_HLT_STOP_HI:`THLC_HLT_STOP_LO]);
	assign tick      = tclk_sync_q[1] & ~tclk_last_q;
	assign syn       = hlt_q[`THLC_HLT_SYNC];
	assign on_eff    = syn ? on_sync_q : en_q;
	assign evt_cyc   = syn ? tick : 1'b1;
	assign src_pol   = src_sync_q[1] ^ hlt_q[`THLC_HLT_POL];
	assign rise      = on_eff & evt_cyc & src_pol & ~src_last_q;
	assign fall      = on_eff & evt_cyc & ~src_pol & src_last_q;
	assign running   = (state_q == thlc_pkg::ST_RUN);
	assign cnt_tick  = on_eff & tick & (ps_cnt_q == ps_q);
	assign match     = (cnt_q == per_eff_q);

	assign start_hit = on_eff & (start_sel == thlc_pkg::START_LEVEL ? src_pol & evt_cyc :
	                             start_sel == thlc_pkg::START_RISE  ? rise :
	                             start_sel == thlc_pkg::START_BOTH  ? rise | fall : 1'b1);
	assign start_evt = start_hit & ~running;
	assign stop_hit  = on_eff & running & (stop_sel == thlc_pkg::STOP_MATCH ? cnt_tick & match :
	                                       stop_sel == thlc_pkg::STOP_RISE  ? rise :
	                                       stop_sel == thlc_pkg::STOP_BOTH  ? rise | fall : 1'b0);
	// capture on rise with stop none
	assign cap_evt   = stop_hit | (running & (stop_sel == thlc_pkg::STOP_NONE) & rise);
	// level start arms only at off-on
	assign first_set = (rst_sel == thlc_pkg::RST_FIRST) &
	                   ((start_sel == thlc_pkg::START_LEVEL || start_sel == thlc_pkg::START_NONE) ?
	                    start_evt : start_hit);
	assign match_rst = running & cnt_tick & match & (rst_sel != thlc_pkg::RST_NONE);
	assign low_rst   = on_eff & running & (rst_sel == thlc_pkg::RST_LOW) & ~src_pol;
	assign first_rst = running & cnt_tick & rst_pend_q;
	assign rst_evt   = match_rst | low_rst | first_rst;
	// run status held low in level reset
	assign run_status = running & ~((rst_sel == thlc_pkg::RST_LOW) & ~src_pol);

	// ****************************************************************
	// bus decode
	// ****************************************************************
	logic                   wr_go, ar_go;
	logic [`THLC_IDX_W-1:0] ar_idx;
	logic                   wr_ctrl, wr_hlt, wr_ps, wr_per_lo, wr_per_hi;
	logic                   cnt_hi_en, cnt_lo_en, wr_cnt;
	logic [7:0]             new_hi, new_lo;
	logic                   ar_mapped, aw_mapped;
	logic [15:0]            view_val;
	logic [31:0]            rd_mux;

	assign awready   = ~aw_full_q & ~bvalid_q;
	assign wready    = ~w_full_q & ~bvalid_q;
	assign arready   = ~rvalid_q;
	assign wr_go     = aw_full_q & w_full_q & ~bvalid_q;
	assign ar_go     = arvalid & ~rvalid_q;
	assign ar_idx    = araddr[15:2];
	assign wr_ctrl   = wr_go & (aw_idx_q == `THLC_IDX_CTRL) & wstrb_q[0];
	assign wr_hlt    = wr_go & (aw_idx_q == `THLC_IDX_HLT) & wstrb_q[0];
	assign wr_ps     = wr_go & (aw_idx_q == `THLC_IDX_PS) & wstrb_q[0];
	assign wr_per_lo = wr_go & (aw_idx_q == `THLC_IDX_PERIOD) & wstrb_q[0];
	assign wr_per_hi = wr_go & (aw_idx_q == `THLC_IDX_PERIOD) & wstrb_q[1];
	// counter writable only in counter view
	assign cnt_hi_en = wr_go & vsel_q & (((aw_idx_q == `THLC_IDX_COUNTER) & wstrb_q[1]) |
	                                     ((aw_idx_q == `THLC_IDX_CNT_HI) & wstrb_q[0]));
	assign cnt_lo_en = wr_go & vsel_q & wstrb_q[0] &
	                   ((aw_idx_q == `THLC_IDX_COUNTER) | (aw_idx_q == `THLC_IDX_CNT_LO));
	assign new_hi    = (aw_idx_q == `THLC_IDX_COUNTER) ? wdata_q[15:8] : wdata_q[7:0];
	assign new_lo    = wdata_q[7:0];
	assign wr_cnt    = cnt_hi_en | cnt_lo_en;
	assign ps_clr    = stop_hit | rst_evt | wr_ps | wr_cnt | cnt_tick;
	assign aw_mapped = (aw_idx_q >= `THLC_IDX_COUNTER) & (aw_idx_q <= `THLC_IDX_CNT_LO);
	assign ar_mapped = (ar_idx >= `THLC_IDX_COUNTER) & (ar_idx <= `THLC_IDX_CNT_LO);
	assign view_val  = vsel_q ? cnt_q : cap_q;

	// read data select; unmapped reads return zero
	assign rd_mux = (ar_idx == `THLC_IDX_COUNTER) ? {16'h0000, view_val} :
	                (ar_idx == `THLC_IDX_CTRL)    ? {24'h000000, run_status, 4'h0, vsel_q, os_q, en_q} :
	                (ar_idx == `THLC_IDX_HLT)     ? {24'h000000, hlt_q} :
	                (ar_idx == `THLC_IDX_PS)      ? {24'h000000, ps_q} :
	                (ar_idx == `THLC_IDX_PERIOD)  ? {16'h0000, per_buf_q} :
	                (ar_idx == `THLC_IDX_CNT_HI)  ? {24'h000000, view_val[15:8]} :
	                (ar_idx == `THLC_IDX_CNT_LO)  ? {24'h000000, view_val[7:0]} : 32'h00000000;

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	// address and data taken in either order, answer one cycle after both
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			aw_idx_q  <= 14'h0000;
			wdata_q   <= 32'h00000000;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `THLC_RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_full_q <= 1'b1;
				aw_idx_q  <= awaddr[15:2];
			end
			if (wvalid && wready) begin
				w_full_q <= 1'b1;
				wdata_q  <= wdata;
				wstrb_q  <= wstrb;
			end
			if (wr_go) begin
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= aw_mapped ? `THLC_RESP_OKAY : `THLC_RESP_SLVERR;
			end else if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// read answer registered one cycle after the address
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= `THLC_RESP_OKAY;
		end else if (ar_go) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_mux;
			rresp_q  <= ar_mapped ? `THLC_RESP_OKAY : `THLC_RESP_SLVERR;
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign bvalid = bvalid_q;
	assign bresp  = bresp_q;
	assign rvalid = rvalid_q;
	assign rdata  = rdata_q;
	assign rresp  = rresp_q;

	// ****************************************************************
	// software registers
	// ****************************************************************
	// hlt and prescaler are unsynchronised; software keeps them still while enabled
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			en_q      <= 1'b0;
			os_q      <= 1'b0;
			vsel_q    <= 1'b0;
			hlt_q     <= `THLC_HLT_RST;
			ps_q      <= `THLC_PS_RST;
			per_buf_q <= `THLC_PER_RST;
		end else begin
			if (wr_ctrl) begin
				en_q   <= wdata_q[`THLC_CTRL_EN];
				os_q   <= wdata_q[`THLC_CTRL_OS];
				vsel_q <= wdata_q[`THLC_CTRL_VSEL];
			end
			// one-shot stop wins over a write
			if (os_q && stop_hit)
				en_q <= 1'b0;
			// taken as written; kept stable by software
			if (wr_hlt)
				hlt_q <= wdata_q[7:0];
			// taken as written; kept stable by software
			if (wr_ps)
				ps_q <= wdata_q[7:0];
			if (wr_per_lo)
				per_buf_q[7:0] <= wdata_q[7:0];
			if (wr_per_hi)
				per_buf_q[15:8] <= wdata_q[15:8];
		end
	end

	// ****************************************************************
	// timer core
	// ****************************************************************
	// enable rises and source samples follow the tick when sync is on; enable low clears on_sync_q at once
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			on_sync_q  <= 1'b0;
			src_last_q <= 1'b0;
		end else begin
			on_sync_q <= en_q & (tick | on_sync_q);
			if (evt_cyc)
				src_last_q <= src_pol;
		end
	end

	// run state
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state_q <= thlc_pkg::ST_IDLE;
		end else begin
			case (state_q)
				thlc_pkg::ST_IDLE: begin
					if (start_evt)
						state_q <= thlc_pkg::ST_RUN;
				end
				thlc_pkg::ST_RUN: begin
					if (stop_hit || !on_eff)
						state_q <= thlc_pkg::ST_IDLE;
				end
				default: state_q <= thlc_pkg::ST_IDLE;
			endcase
		end
	end

	// prescaler runs whenever enabled, started or not
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ps_cnt_q <= 8'h00;
		end else if (ps_clr) begin
			ps_cnt_q <= 8'h00;
		end else if (on_eff && tick) begin
			ps_cnt_q <= ps_cnt_q + 8'h01;
		end
	end

	// counter, pending first-clock reset, period and capture
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			cnt_q      <= `THLC_CNT_RST;
			cap_q      <= `THLC_CNT_RST;
			per_eff_q  <= `THLC_PER_RST;
			rst_pend_q <= 1'b0;
		end else begin
			if (wr_cnt)
				cnt_q <= {cnt_hi_en ? new_hi : cnt_q[15:8], cnt_lo_en ? new_lo : cnt_q[7:0]};
			else if (rst_evt)
				cnt_q <= `THLC_CNT_RST;
			else if (running && cnt_tick && !stop_hit)
				cnt_q <= cnt_q + 16'h0001;
			if (first_set)
				rst_pend_q <= 1'b1;
			else if (first_rst || !on_eff)
				rst_pend_q <= 1'b0;
			if (rst_evt || stop_hit)
				per_eff_q <= per_buf_q;
			if (cap_evt)
				cap_q <= cnt_q;
		end
	end

	assign counter_run = running;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	sequence s_enable_low;
		!en_q [*2];
	endsequence

	sequence s_pending_fire;
		rst_pend_q && running && cnt_tick && !wr_cnt && !first_set;
	endsequence

	a_start_runs:     assert property (start_evt |=> running)
		else $error("start event did not enter run");
	a_stop_capture:   assert property (stop_hit |=> !running && cap_q == $past(cnt_q))
		else $error("stop did not halt and capture");
	a_idle_cap_hold:  assert property (!running |=> $stable(cap_q))
		else $error("capture changed while stopped");
	a_off_stops:      assert property (s_enable_low |=> !running)
		else $error("counter kept running with enable low");
	a_oneshot_clear:  assert property (os_q && stop_hit |=> !en_q)
		else $error("one-shot stop left enable set");
	a_period_reload:  assert property ((rst_evt || stop_hit) |=> per_eff_q == $past(per_buf_q))
		else $error("effective period not reloaded");
	a_prescale_bound: assert property (on_eff && !$past(wr_ps) |-> ps_cnt_q <= ps_q)
		else $error("prescale count passed its value");
	a_level_zero:     assert property (low_rst && !wr_cnt |=> cnt_q == 16'h0000)
		else $error("level reset did not clear counter");
	a_run_status_low: assert property (rst_sel == thlc_pkg::RST_LOW && !src_pol |-> !run_status)
		else $error("run status high during level reset");
	a_first_reset:    assert property (s_pending_fire |=> cnt_q == 16'h0000 && !rst_pend_q)
		else $error("first-clock reset not applied");

endmodule : thlc_top

// file: dv/thlc_source_model.sv
// far side model: free-running timer input clock and the external reset source
`timescale 1ns/1ns
module thlc_source_model (
	input  wire logic mclk,
	input  wire logic rstn,
	input  wire logic level_req,
	output logic      timer_clock_in,
	output logic      external_reset_source
);
	logic [2:0] div_q;

	// oscillator runs free: 8 mclk a period, 4 high and 4 low
	always_ff @(posedge mclk) begin
		if (!rstn)
			div_q <= 3'h0;
		else
			div_q <= div_q + 3'h1;
	end
	assign timer_clock_in = div_q[2];

	// source moves mid low phase only, far from the clock edge,
	// so synchronised mode never races the sampling
	always_ff @(posedge mclk) begin
		if (!rstn)
			external_reset_source <= 1'b0;
		else if (div_q == 3'h1)
			external_reset_source <= level_req;
	end
endmodule : thlc_source_model

// file: dv/test_timer_hw_limit_control.sv
// self-checking bench of the timer start/reset/stop control block
`timescale 1ns/1ns
`include "thlc_defines.svh"
module test_timer_hw_limit_control;
	logic        mclk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, level_req, counter_run;
	logic        timer_clock_in, external_reset_source;
	logic [15:0] awaddr, araddr, d16;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rsp;
	int          seed, miscompares, cmp_count, cycles, per, pre, n;
	logic [13:0] ridx [5] = '{`THLC_IDX_CTRL, `THLC_IDX_HLT, `THLC_IDX_PS,
		`THLC_IDX_PERIOD, `THLC_IDX_COUNTER};
	logic [31:0] rexp [5] = '{32'h0, 32'h40, 32'h0, 32'hffff, 32'h0};

	// clock and hang guard
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			report_and_stop();
		end
	end

	thlc_top dut (.mclk(mclk), .rstn(rstn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .timer_clock_in(timer_clock_in),
		.external_reset_source(external_reset_source), .counter_run(counter_run));
	thlc_source_model src (.mclk(mclk), .rstn(rstn), .level_req(level_req),
		.timer_clock_in(timer_clock_in), .external_reset_source(external_reset_source));

	// ****************************************************************
	// bus and checking tasks
	// ****************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// whole one-shot match run in mclk cycles: period plus one count ticks
	function automatic int span(input int p, input int s);
		return 8 * (p + 1) * (s + 1);
	endfunction : span

	task automatic report_and_stop();
		if (miscompares == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop

	// bready stays high, so the response is taken where bvalid is seen
	task automatic wr(input logic [13:0] idx, input logic [31:0] d);
		awaddr  <= {idx, 2'h0};
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		forever begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		rsp = bresp;
	endtask : wr

	task automatic rd_reg(input logic [13:0] idx);
		araddr  <= {idx, 2'h0};
		arvalid <= 1'b1;
		forever begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rd  = rdata;
		rsp = rresp;
	endtask : rd_reg

	task automatic ticks(input int t);
		repeat (t * 8) @(posedge mclk);
	endtask : ticks

	// level reset with the source low loads the buffered period
	task automatic prime(input logic sync);
		wr(`THLC_IDX_HLT, (32'(sync) << 6) | 32'h4);
		wr(`THLC_IDX_CTRL, 32'h1);
		ticks(6);
		rd_reg(`THLC_IDX_CTRL);
		check(32'(rd[7]), 32'h0);
		wr(`THLC_IDX_CTRL, 32'h0);
		ticks(3);
	endtask : prime

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{awvalid, wvalid, arvalid, level_req, rstn} = '0;
		{bready, rready} = 2'h3;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		seed = 12122;
		cycles = 0;
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		// reset values and unmapped places
		for (int i = 0; i < 5; i++) begin
			rd_reg(ridx[i]);
			check(rd, rexp[i]);
		end
		rd_reg(14'h03a0);
		check(32'(rsp), 32'(`THLC_RESP_SLVERR));
		wr(14'h0010, 32'h5a);
		check(32'(rsp), 32'(`THLC_RESP_SLVERR));
		wr(`THLC_IDX_CTRL, 32'h4);
		wr(`THLC_IDX_CNT_HI, 32'hab);
		wr(`THLC_IDX_CNT_LO, 32'hcd);
		rd_reg(`THLC_IDX_COUNTER);
		check(rd, 32'habcd);
		d16 = 16'($random(seed));
		wr(`THLC_IDX_COUNTER, {16'h0, d16});
		rd_reg(`THLC_IDX_CNT_HI);
		check(rd, {24'h0, d16[15:8]});
		rd_reg(`THLC_IDX_CNT_LO);
		check(rd, {24'h0, d16[7:0]});
		wr(`THLC_IDX_CTRL, 32'h0);
		rd_reg(`THLC_IDX_COUNTER);
		check(rd, 32'h0);
		// one-shot match stop, both sync modes, random period, prescale zero then random
		for (int s = 0; s < 2; s++) begin
			for (int j = 0; j < 2; j++) begin
				per = 4 + ($unsigned($random(seed)) % 8);
				pre = j * (1 + ($unsigned($random(seed)) % 3));
				wr(`THLC_IDX_PERIOD, 32'(per));
				prime(1'(s));
				wr(`THLC_IDX_CTRL, 32'h4);
				wr(`THLC_IDX_COUNTER, 32'h0);
				wr(`THLC_IDX_HLT, 32'(s * 64 + 3));
				wr(`THLC_IDX_PS, 32'(pre));
				wr(`THLC_IDX_CTRL, 32'h3);
				n = 0;
				while (counter_run !== 1'b1 && n < 200) begin
					@(posedge mclk);
					n++;
				end
				check(32'(counter_run), 32'h1);
				while (counter_run !== 1'b0 && n < 4000) begin
					@(posedge mclk);
					n++;
				end
				check(32'(n > span(per - 2, pre) - 16
					&& n < span(per, pre) + 80), 32'h1);
				rd_reg(`THLC_IDX_COUNTER);
				check(rd, 32'(per));
				rd_reg(`THLC_IDX_CTRL);
				check(32'(rd[0]), 32'h0);
			end
		end
		// start on active edge, stop on either edge, both polarities
		wr(`THLC_IDX_PS, 32'h0);
		for (int p = 0; p < 2; p++) begin
			level_req <= 1'(p);
			wr(`THLC_IDX_CTRL, 32'h4);
			wr(`THLC_IDX_COUNTER, 32'h0);
			wr(`THLC_IDX_CTRL, 32'h0);
			// second pass starts on either edge as well as inverting
			wr(`THLC_IDX_HLT, p ? 32'hd1 : 32'h61);
			level_req <= 1'(1 - p);
			ticks(4);
			check(32'(counter_run), 32'h0);
			level_req <= 1'(p);
			ticks(4);
			wr(`THLC_IDX_CTRL, 32'h1);
			ticks(4);
			check(32'(counter_run), 32'h0);
			level_req <= 1'(1 - p);
			ticks(5);
			check(32'(counter_run), 32'h1);
			ticks(4);
			level_req <= 1'(p);
			ticks(5);
			check(32'(counter_run), 32'h0);
			rd_reg(`THLC_IDX_CTRL);
			check(32'(rd[0]), 32'h1);
			rd_reg(`THLC_IDX_COUNTER);
			check(32'(rd > 0 && rd < 80), 32'h1);
			wr(`THLC_IDX_CTRL, 32'h0);
		end
		// free run wrapping at period, capture on rise, software stop
		level_req <= 1'b0;
		wr(`THLC_IDX_CTRL, 32'h4);
		wr(`THLC_IDX_COUNTER, 32'h0);
		wr(`THLC_IDX_CTRL, 32'h0);
		wr(`THLC_IDX_HLT, 32'h4c);
		wr(`THLC_IDX_CTRL, 32'h1);
		ticks(4);
		check(32'(counter_run), 32'h1);
		ticks(30);
		level_req <= 1'b1;
		ticks(4);
		rd_reg(`THLC_IDX_COUNTER);
		check(32'(rd <= per), 32'h1);
		check(32'(counter_run), 32'h1);
		wr(`THLC_IDX_CTRL, 32'h0);
		ticks(1);
		check(32'(counter_run), 32'h0);
		// level start with first-clock reset: cleared once, at off-on only
		level_req <= 1'b0;
		d16 = 16'($random(seed)) | 16'h8000;
		wr(`THLC_IDX_PERIOD, 32'hffff);
		wr(`THLC_IDX_CTRL, 32'h4);
		wr(`THLC_IDX_COUNTER, {16'h0, d16});
		wr(`THLC_IDX_CTRL, 32'h0);
		wr(`THLC_IDX_HLT, 32'h78);
		wr(`THLC_IDX_CTRL, 32'h1);
		level_req <= 1'b1;
		ticks(4);
		level_req <= 1'b0;
		ticks(4);
		rd_reg(`THLC_IDX_CTRL);
		check(32'(rd[7]), 32'h1);
		ticks(8);
		level_req <= 1'b1;
		ticks(4);
		rd_reg(`THLC_IDX_COUNTER);
		pre = int'(rd);
		check(32'(rd > 12 && rd < 20), 32'h1);
		wr(`THLC_IDX_CTRL, 32'h4);
		rd_reg(`THLC_IDX_COUNTER);
		check(32'(rd > pre), 32'h1);
		wr(`THLC_IDX_CTRL, 32'h0);
		report_and_stop();
	end
endmodule : test_timer_hw_limit_control
